// ==== verilog/vcs_pkg.sv ====
package vcs_pkg;

   // ---------------------------------------------
   // Register bus layout
   // ---------------------------------------------
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam logic [3:0] ADDR_MISC = 4'h0;
   localparam logic [3:0] ADDR_SETUP1 = 4'h4;
   localparam logic [3:0] ADDR_SETUP2 = 4'h8;
   localparam logic [3:0] ADDR_CONFIG = 4'hc;
   localparam logic [7:0] RD_UNMAPPED = 8'h00;

   // ---------------------------------------------
   // Reset values and field positions
   // ---------------------------------------------
   localparam logic [7:0] RST_MISC = 8'h00;
   localparam logic [7:0] RST_SETUP = 8'h00;
   localparam logic [7:0] RST_CONFIG = 8'h00;
   localparam int CFG_DIR_BIT = 3;
   localparam int SETUP2_CLK2_BIT = 1;
   localparam int MISC_SEL_LO = 2;
   localparam int MISC_SEL_HI = 3;
   localparam logic [1:0] SEL_PRIMARY = 2'h0;
   localparam logic [1:0] SEL_SECOND = 2'h1;
   localparam logic [1:0] SEL_THIRD = 2'h2;

   // ---------------------------------------------
   // Host port and timing
   // ---------------------------------------------
   localparam logic [15:0] MISC_IO_PORT = 16'h03c2;
   localparam logic [9:0] PIX_PRIMARY = 10'h280;
   localparam logic [9:0] PIX_SECOND = 10'h2d0;
   localparam int PRIMARY_FREQ_KHZ = 25175;
   localparam int SECOND_FREQ_KHZ = 28322;
   localparam int RESET_MIN_CYCLES = 10;

   // ---------------------------------------------
   // Types
   // ---------------------------------------------
   typedef enum logic [1:0] {SRC_PRIMARY, SRC_SECOND, SRC_THIRD} vcs_src_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } vcs_reg_req_t;

   typedef struct packed {
      logic wr;
      logic [15:0] addr;
      logic [7:0] data;
   } vcs_io_req_t;

   typedef struct packed {
      logic in;
      logic out;
      logic oe;
   } vcs_pin_t;

endpackage

// ==== verilog/vcs_clock_select.sv ====
`timescale 1ns/1ps
module vcs_clock_select
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [15:0] memDataBus,
   input wire vcs_pkg::vcs_io_req_t ioReq,
   input wire vcs_pkg::vcs_reg_req_t regReq,
   output logic [7:0] regRdData,
   input wire logic primaryVideoClock,
   input wire logic secondVideoClockIn,
   output logic secondVideoClockOut,
   output logic secondVideoClockOe,
   input wire logic thirdVideoClockIn,
   output logic thirdVideoClockOut,
   output logic thirdVideoClockOe,
   output vcs_pkg::vcs_src_t clkSelect,
   output logic [9:0] pixelsPerLine,
   output logic selClkLevel
);

   // ---------------------------------------------
   // State
   // ---------------------------------------------
   typedef struct packed {
      logic strapDone;
      logic [7:0] setup1;
      logic [7:0] setup2;
      logic [7:0] cfgReg;
      logic [7:0] misc;
      logic clk1Low;
      vcs_pkg::vcs_src_t clkSel;
      logic [9:0] pixels;
      logic [7:0] rdData;
      logic clkLevel;
   } vcs_state_t;

   typedef struct packed {
      logic [15:0] md;
      vcs_pkg::vcs_io_req_t io;
      logic [2:0] vclk;
   } vcs_sync_t;

   vcs_state_t st_r;
   vcs_state_t st_nxt;
   vcs_sync_t syA_r;
   vcs_sync_t syB_r;
   logic ioHit;
   logic outMode;

   // ---------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------
   // Left free of reset so the strap levels are settled at release
   always_ff @(posedge clk)
   begin
      syA_r.md <= memDataBus;
      syA_r.io <= ioReq;
      syA_r.vclk <= {thirdVideoClockIn, secondVideoClockIn,
                     primaryVideoClock};
      syB_r <= syA_r;
   end

   assign outMode = st_r.cfgReg[vcs_pkg::CFG_DIR_BIT];
   assign ioHit = syB_r.io.wr && (syB_r.io.addr == vcs_pkg::MISC_IO_PORT);

   // ---------------------------------------------
   // Next state
   // ---------------------------------------------
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.rdData = vcs_pkg::RD_UNMAPPED;
      // Strap capture at the first edge after release
      if (!st_r.strapDone)
      begin
         st_nxt.strapDone = 1'b1;
         st_nxt.setup1 = syB_r.md[15:8];
         st_nxt.cfgReg = ~syB_r.md[7:0];
      end
      // Host writes to the misc output port
      if (ioHit)
      begin
         st_nxt.misc = syB_r.io.data;
      end
      st_nxt.clk1Low = ioHit && outMode;
      // Software writes, strapped values hold otherwise
      if (regReq.wr && st_r.strapDone)
      begin
         case (regReq.addr)
            vcs_pkg::ADDR_MISC: st_nxt.misc = regReq.wdata;
            vcs_pkg::ADDR_SETUP1: st_nxt.setup1 = regReq.wdata;
            vcs_pkg::ADDR_SETUP2: st_nxt.setup2 = regReq.wdata;
            default: st_nxt.setup2 = st_r.setup2;
         endcase
      end
      if (regReq.rd)
      begin
         case (regReq.addr)
            vcs_pkg::ADDR_MISC: st_nxt.rdData = st_r.misc;
            vcs_pkg::ADDR_SETUP1: st_nxt.rdData = st_r.setup1;
            vcs_pkg::ADDR_SETUP2: st_nxt.rdData = st_r.setup2;
            vcs_pkg::ADDR_CONFIG: st_nxt.rdData = st_r.cfgReg;
            default: st_nxt.rdData = vcs_pkg::RD_UNMAPPED;
         endcase
      end
      // Clock source selection
      if (outMode)
      begin
         st_nxt.clkSel = vcs_pkg::SRC_PRIMARY;
      end
      else
      begin
         case (st_r.misc[vcs_pkg::MISC_SEL_HI:vcs_pkg::MISC_SEL_LO])
            vcs_pkg::SEL_PRIMARY:
               st_nxt.clkSel = vcs_pkg::SRC_PRIMARY;
            vcs_pkg::SEL_SECOND: st_nxt.clkSel = vcs_pkg::SRC_SECOND;
            vcs_pkg::SEL_THIRD: st_nxt.clkSel = vcs_pkg::SRC_THIRD;
            default: st_nxt.clkSel = vcs_pkg::SRC_PRIMARY;
         endcase
      end
      // Line width and selected clock level
      case (st_r.clkSel)
         vcs_pkg::SRC_PRIMARY:
         begin
            st_nxt.pixels = vcs_pkg::PIX_PRIMARY;
            st_nxt.clkLevel = syB_r.vclk[0];
         end
         vcs_pkg::SRC_SECOND:
         begin
            st_nxt.pixels = vcs_pkg::PIX_SECOND;
            st_nxt.clkLevel = syB_r.vclk[1];
         end
         vcs_pkg::SRC_THIRD:
         begin
            st_nxt.pixels = vcs_pkg::PIX_PRIMARY;
            st_nxt.clkLevel = syB_r.vclk[2];
         end
         default:
         begin
            st_nxt.pixels = vcs_pkg::PIX_PRIMARY;
            st_nxt.clkLevel = syB_r.vclk[0];
         end
      endcase
   end

   // ---------------------------------------------
   // State register
   // ---------------------------------------------
   // All timing runs on the memory clock
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_r.strapDone <= 1'b0;
         st_r.setup1 <= vcs_pkg::RST_SETUP;
         st_r.setup2 <= vcs_pkg::RST_SETUP;
         st_r.cfgReg <= vcs_pkg::RST_CONFIG;
         st_r.misc <= vcs_pkg::RST_MISC;
         st_r.clk1Low <= 1'b0;
         st_r.clkSel <= vcs_pkg::SRC_PRIMARY;
         st_r.pixels <= vcs_pkg::PIX_PRIMARY;
         st_r.rdData <= vcs_pkg::RD_UNMAPPED;
         st_r.clkLevel <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // ---------------------------------------------
   // Outputs
   // ---------------------------------------------
   assign regRdData = st_r.rdData;
   assign secondVideoClockOe = outMode;
   assign thirdVideoClockOe = outMode;
   assign secondVideoClockOut = !st_r.clk1Low;
   assign thirdVideoClockOut =
      st_r.setup2[vcs_pkg::SETUP2_CLK2_BIT];
   assign clkSelect = st_r.clkSel;
   assign pixelsPerLine = st_r.pixels;
   assign selClkLevel = st_r.clkLevel;

   // ---------------------------------------------
   // Checks
   // ---------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   sequence ioWriteSeen;
      ioHit && outMode;
   endsequence

   sequence setup2Untouched;
      st_r.strapDone && !(regReq.wr && regReq.addr == vcs_pkg::ADDR_SETUP2);
   endsequence

   chk_config_strap: assert property (
      $rose(st_r.strapDone) |-> st_r.cfgReg == ~$past(syB_r.md[7:0]))
      else $error("config not inverted strap");

   chk_setup_strap: assert property (
      $rose(st_r.strapDone) |-> st_r.setup1 == $past(syB_r.md[15:8]))
      else $error("setup not loaded from strap");

   chk_dir_strap: assert property (
      $rose(st_r.strapDone) |-> secondVideoClockOe == !$past(syB_r.md[3]))
      else $error("direction not from data line three");

   chk_dir_pair: assert property (
      thirdVideoClockOe == secondVideoClockOe)
      else $error("pin directions differ");

   chk_third_value: assert property (
      thirdVideoClockOe |-> thirdVideoClockOut == st_r.setup2[1])
      else $error("third pin not setup bit");

   chk_write_pulse: assert property (
      ioWriteSeen |=> !secondVideoClockOut)
      else $error("no low pulse on port write");

   chk_pulse_idle: assert property (
      !(ioHit && outMode) |=> secondVideoClockOut)
      else $error("second pin low without write");

   chk_input_select: assert property (
      !outMode && st_r.misc[3:2] == 2'h0
      |=> clkSelect == vcs_pkg::SRC_PRIMARY)
      else $error("primary clock not selected");

   chk_output_primary: assert property (
      outMode |=> clkSelect == vcs_pkg::SRC_PRIMARY)
      else $error("output mode selected other clock");

   chk_pixels_primary: assert property (
      clkSelect == vcs_pkg::SRC_PRIMARY |=> pixelsPerLine == 10'h280)
      else $error("primary width not 640");

   chk_pixels_second: assert property (
      clkSelect == vcs_pkg::SRC_SECOND |=> pixelsPerLine == 10'h2d0)
      else $error("second width not 720");

   chk_hold_setup: assert property (
      setup2Untouched |=> $stable(st_r.setup2))
      else $error("setup changed without write");

   chk_hold_config: assert property (
      st_r.strapDone |=> $stable(st_r.cfgReg) [*2])
      else $error("config changed after capture");

   chk_strap_sticky: assert property (
      st_r.strapDone |=> st_r.strapDone)
      else $error("strap flag dropped");

   chk_read_data: assert property (
      regReq.rd && regReq.addr == vcs_pkg::ADDR_SETUP2
      |=> regRdData == $past(st_r.setup2))
      else $error("read data not setup register");

   chk_read_idle: assert property (
      !regReq.rd |=> regRdData == vcs_pkg::RD_UNMAPPED)
      else $error("read data stands too long");

   chk_write_third: assert property (
      regReq.wr && st_r.strapDone && regReq.addr == vcs_pkg::ADDR_SETUP2
      |=> thirdVideoClockOut == $past(regReq.wdata[1]))
      else $error("third pin not written value");

   chk_misc_io: assert property (
      ioHit && !(regReq.wr && st_r.strapDone &&
         regReq.addr == vcs_pkg::ADDR_MISC)
      |=> st_r.misc == $past(syB_r.io.data))
      else $error("port write did not load misc");

   chk_pixels_third: assert property (
      clkSelect == vcs_pkg::SRC_THIRD |=> pixelsPerLine == 10'h280)
      else $error("third width not 640");

   chk_level_primary: assert property (
      clkSelect == vcs_pkg::SRC_PRIMARY
      |=> selClkLevel == $past(syB_r.vclk[0]))
      else $error("level not from primary clock");

   chk_level_second: assert property (
      clkSelect == vcs_pkg::SRC_SECOND
      |=> selClkLevel == $past(syB_r.vclk[1]))
      else $error("level not from second clock");

endmodule

// ==== verif/vcs_clk_mux_model.sv ====
`timescale 1ns/1ps
module vcs_clk_mux_model
(
   input wire logic selOut2,
   input wire logic selOe2,
   input wire logic selOut3,
   input wire logic selOe3,
   output logic primaryClk,
   output logic pin2,
   output logic pin3
);
   // ------------------------------
   // Oscillators, free running
   // ------------------------------
   logic osc2;
   logic osc3;
   initial
   begin
      primaryClk = 1'b0;
      forever #19.861 primaryClk = ~primaryClk;
   end
   initial
   begin
      osc2 = 1'b0;
      forever #17.654 osc2 = ~osc2;
   end
   initial
   begin
      osc3 = 1'b1;
      forever #16.0 osc3 = ~osc3;
   end
   // Select lines win the pin when driven
   assign pin2 = selOe2 ? selOut2 : osc2;
   assign pin3 = selOe3 ? selOut3 : osc3;
endmodule

// ==== verif/vcs_clock_select_bench.sv ====
`timescale 1ns/1ps
module vcs_clock_select_bench;
   logic clk;
   logic rst_b;
   logic [15:0] memDataBus;
   vcs_pkg::vcs_io_req_t ioReq;
   vcs_pkg::vcs_reg_req_t regReq;
   logic [7:0] regRdData;
   logic primaryClk;
   logic in2;
   logic out2;
   logic oe2;
   logic in3;
   logic out3;
   logic oe3;
   vcs_pkg::vcs_src_t clkSelect;
   logic [9:0] pixelsPerLine;
   int errorCnt;
   int nCompared;
   logic [15:0] md;
   logic [7:0] d;
   logic [7:0] e;
   vcs_pkg::vcs_src_t s;
   logic selLvl;
   logic [2:0] lvlP1;
   logic [2:0] lvlP2;
   logic lvlExp;

   vcs_clock_select vcs_clock_select_i
   (
      .clk(clk), .rst_b(rst_b), .memDataBus(memDataBus),
      .ioReq(ioReq), .regReq(regReq), .regRdData(regRdData),
      .primaryVideoClock(primaryClk), .secondVideoClockIn(in2),
      .secondVideoClockOut(out2), .secondVideoClockOe(oe2),
      .thirdVideoClockIn(in3), .thirdVideoClockOut(out3),
      .thirdVideoClockOe(oe3), .clkSelect(clkSelect),
      .pixelsPerLine(pixelsPerLine), .selClkLevel(selLvl)
   );
   vcs_clk_mux_model vcs_clk_mux_model_i
   (
      .selOut2(out2), .selOe2(oe2), .selOut3(out3), .selOe3(oe3),
      .primaryClk(primaryClk), .pin2(in2), .pin3(in3)
   );

   // ------------------------------
   // Tasks
   // ------------------------------
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      nCompared++;
      if (got !== exp)
      begin
         errorCnt++;
         $display("wrong value at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      regReq <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      regReq.wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      regReq.rd <= 1'b0;
      #1;
      check({8'h00, regRdData}, {8'h00, exp});
   endtask
   task automatic do_reset(input logic [15:0] m);
      @(posedge clk);
      rst_b <= 1'b0;
      memDataBus <= m;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
   endtask
   function automatic vcs_pkg::vcs_src_t exp_sel(input logic oe,
      input logic [1:0] v);
      if (oe || v == 2'h0 || v == 2'h3)
         return vcs_pkg::SRC_PRIMARY;
      return (v == 2'h1) ? vcs_pkg::SRC_SECOND : vcs_pkg::SRC_THIRD;
   endfunction
   task automatic results;
      if (errorCnt == 0 && nCompared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // ------------------------------
   // Stimulus
   // ------------------------------
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Selected clock level after two sampling stages
   always @(posedge clk)
   begin
      lvlP1 <= {in3, in2, primaryClk};
      lvlP2 <= lvlP1;
      lvlExp <= lvlP2[2'(clkSelect)];
   end
   initial
   begin
      #100000;
      errorCnt++;
      results;
   end
   initial
   begin
      rst_b = 1'b0;
      memDataBus = 16'h0000;
      ioReq = '0;
      regReq = '0;
      errorCnt = 0;
      nCompared = 0;
      void'($urandom(32'hd4621fff));
      for (int k = 0; k < 4; k++)
      begin
         md = 16'($urandom());
         md[3] = k[0];
         do_reset(md);
         rd_reg(vcs_pkg::ADDR_CONFIG, ~md[7:0]);
         rd_reg(vcs_pkg::ADDR_SETUP1, md[15:8]);
         check(16'(oe2), 16'(!md[3]));
         check(16'(oe3), 16'(!md[3]));
         wr_reg(vcs_pkg::ADDR_CONFIG, md[7:0]);
         rd_reg(vcs_pkg::ADDR_CONFIG, ~md[7:0]);
         rd_reg(4'h2, vcs_pkg::RD_UNMAPPED);
         d = 8'($urandom());
         wr_reg(vcs_pkg::ADDR_SETUP2, d);
         #1;
         if (!md[3])
            check(16'(out3), 16'(d[1]));
         for (int v = 0; v < 4; v++)
         begin
            d = 8'($urandom());
            d[3:2] = v[1:0];
            wr_reg(vcs_pkg::ADDR_MISC, d);
            repeat (2) @(posedge clk);
            #1;
            s = exp_sel(!md[3], d[3:2]);
            check(16'(clkSelect), 16'(s));
            check(16'(pixelsPerLine), 16'((s == vcs_pkg::SRC_SECOND) ?
               vcs_pkg::PIX_SECOND : vcs_pkg::PIX_PRIMARY));
            check(16'(selLvl), 16'(lvlExp));
         end
         e = 8'($urandom());
         @(posedge clk);
         ioReq <= '{wr: 1'b1, addr: k[1] ? vcs_pkg::MISC_IO_PORT :
            16'h03c3, data: e};
         repeat (3) @(posedge clk);
         #1;
         check(16'(out2), 16'(!(k[1] && !md[3])));
         @(posedge clk);
         ioReq.wr <= 1'b0;
         repeat (4) @(posedge clk);
         #1;
         check(16'(out2), 16'h0001);
         rd_reg(vcs_pkg::ADDR_MISC, k[1] ? e : d);
      end
      results;
   end
endmodule
